// ==== design/tmt_master_tx.sv ====
// two-wire master sender: control, status, data registers and the bus engine
// Functional notes
// - four roles exist; software picks legal ones
// - master starts after START; direction bit selects
// - START only once bus is free
// - after START set flag, status 0x08
// - after address: flag, 0x18/0x20/0x38
// - data write while flag low: discard, collision
// - start while owning bus: repeated START, 0x10
// - after repeated START bus stays owned
// - flag set holds transfer suspended
// - clock held low while flag set; the code releases it after arbitration lost
// - no flag after STOP sent
// - stop bit self clears after STOP
// - arbitration lost: 0x38, release or restart
//
// The address map and strobed register access were decided locally.
module tmt_master_tx #(
   parameter int HALF_CYCLES = tmt_pkg::HALF_CYC
) (
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_nrst,
   // register port
   input  wire logic [1:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // two-wire bus, open drain
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_scl,
   output logic            o_scl_oe,
   output logic            o_sda,
   output logic            o_sda_oe,
   // mode indication
   output logic            o_mode_send,
   output logic            o_mode_recv
);
   typedef enum {S_IDLE, S_WAITFREE, S_START, S_HOLD, S_BIT, S_ACK, S_STOP} tmt_state_e;

   tmt_state_e  state_reg, state_next;
   logic [7:0]  ctrl_reg, ctrl_next;
   logic [7:0]  stat_reg, stat_next;
   logic [7:0]  data_reg, data_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [1:0]  ph_reg, ph_next;
   logic [3:0]  bit_reg, bit_next;
   logic        addr_reg, addr_next;
   logic        own_reg, own_next;
   logic        scll_reg, scll_next;
   logic        sdal_reg, sdal_next;
   logic        send_reg, send_next;
   logic        recv_reg, recv_next;
   logic        busy_reg, busy_next;
   logic [1:0]  scl_s, sda_s;
   logic        sda_d;

   // two-stage synchronisers for the bus lines
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         sda_d <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], i_scl};
         sda_s <= {sda_s[0], i_sda};
         sda_d <= sda_s[1];
      end
   end

   // bus busy tracking from start and stop seen on the lines
   always_comb begin
      busy_next = busy_reg;
      if (scl_s[1] && sda_d && !sda_s[1]) begin
         busy_next = 1'b1;
      end else if (scl_s[1] && !sda_d && sda_s[1]) begin
         busy_next = 1'b0;
      end
   end

   // main next-state logic: registers and bus engine
   always_comb begin
      logic wr_ctrl;
      logic half;
      wr_ctrl    = i_wr && (i_addr == tmt_pkg::ADDR_CTRL);
      half       = (cnt_reg >= 16'(HALF_CYCLES - 1));
      state_next = state_reg;
      ctrl_next  = ctrl_reg;
      stat_next  = stat_reg;
      data_next  = data_reg;
      cnt_next   = half ? 16'h0000 : cnt_reg + 16'h0001;
      ph_next    = ph_reg;
      bit_next   = bit_reg;
      addr_next  = addr_reg;
      own_next   = own_reg;
      scll_next  = scll_reg;
      sdal_next  = sdal_reg;
      send_next  = send_reg;
      recv_next  = recv_reg;
      // software side of the control register
      // control field positions
      if (wr_ctrl) begin
         ctrl_next[tmt_pkg::CTL_ACKEN] = i_wdata[tmt_pkg::CTL_ACKEN];
         ctrl_next[tmt_pkg::CTL_START] = i_wdata[tmt_pkg::CTL_START];
         ctrl_next[tmt_pkg::CTL_STOP]  = i_wdata[tmt_pkg::CTL_STOP];
         ctrl_next[tmt_pkg::CTL_EN]    = i_wdata[tmt_pkg::CTL_EN];
         ctrl_next[tmt_pkg::CTL_IRQEN] = i_wdata[tmt_pkg::CTL_IRQEN];
         if (i_wdata[tmt_pkg::CTL_FLAG]) begin
            ctrl_next[tmt_pkg::CTL_FLAG] = 1'b0;
            ctrl_next[tmt_pkg::CTL_WCOL] = 1'b0;
         end
      end
      if (i_wr && i_addr == tmt_pkg::ADDR_DATA) begin
         if (ctrl_reg[tmt_pkg::CTL_FLAG]) begin
            data_next = i_wdata;
         end else begin
            ctrl_next[tmt_pkg::CTL_WCOL] = 1'b1;
         end
      end
      case (state_reg)
         S_IDLE: begin
            // request waits for a free bus
            if (ctrl_reg[tmt_pkg::CTL_EN] && ctrl_reg[tmt_pkg::CTL_START]
                && !ctrl_reg[tmt_pkg::CTL_FLAG]) begin
               state_next = S_WAITFREE;
            end
         end
         S_WAITFREE: begin
            if (!busy_reg && half) begin
               state_next = S_START;
               sdal_next  = 1'b1;
               ph_next    = 2'h0;
            end
         end
         S_START: begin
            if (half) begin
               if (ph_reg == 2'h0 && own_reg) begin
                  scll_next = 1'b0; // repeated start: pull sda after scl rises
                  sdal_next = 1'b0;
                  ph_next   = 2'h1;
               end else if (ph_reg == 2'h1 && own_reg) begin
                  scll_next = 1'b0;
                  sdal_next = 1'b1;
                  ph_next   = 2'h2;
               end else begin
                  scll_next = 1'b1;
                  stat_next = own_reg ? tmt_pkg::ST_RSTART : tmt_pkg::ST_START;
                  ctrl_next[tmt_pkg::CTL_FLAG] = 1'b1;
                  own_next   = 1'b1;
                  addr_next  = 1'b1;
                  state_next = S_HOLD;
               end
            end
         end
         S_HOLD: begin
            // scl held low while flag set and the bus is owned, released after arbitration lost
            scll_next = own_reg;
            // lost bus is left alone, a pending start retries once free
            if (!ctrl_reg[tmt_pkg::CTL_FLAG] && !own_reg) begin
               state_next = S_IDLE;
            end else if (!ctrl_reg[tmt_pkg::CTL_FLAG] && half) begin
               if (ctrl_reg[tmt_pkg::CTL_STOP]) begin
                  sdal_next  = 1'b1;
                  ph_next    = 2'h0;
                  state_next = S_STOP;
               end else if (ctrl_reg[tmt_pkg::CTL_START]) begin
                  sdal_next  = 1'b0;
                  ph_next    = 2'h0;
                  state_next = S_START;
               end else begin
                  bit_next   = 4'(tmt_pkg::BIT_LAST);
                  sdal_next  = !data_reg[tmt_pkg::BIT_LAST];
                  ph_next    = 2'h0;
                  state_next = S_BIT;
               end
            end
         end
         S_BIT, S_ACK: begin
            if (half) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == 2'h0) begin
                  scll_next = 1'b0;
               end else if (ph_reg == 2'h1 && state_reg == S_BIT
                            && sdal_reg == 1'b0 && !sda_s[1]) begin
                  scll_next  = 1'b0;
                  sdal_next  = 1'b0;
                  own_next   = 1'b0;
                  stat_next  = tmt_pkg::ST_ARB_LOST;
                  ctrl_next[tmt_pkg::CTL_FLAG] = 1'b1;
                  state_next = S_HOLD;
               end else if (ph_reg == 2'h1) begin
                  scll_next = 1'b1;
                  ph_next   = 2'h0;
                  if (state_reg == S_ACK) begin
                     if (addr_reg) begin
                        stat_next = sda_s[1] ? tmt_pkg::ST_ADDR_NACK : tmt_pkg::ST_ADDR_ACK;
                     end else begin
                        stat_next = sda_s[1] ? tmt_pkg::ST_DATA_NACK : tmt_pkg::ST_DATA_ACK;
                     end
                     if (addr_reg) begin
                        send_next = !data_reg[0];
                        recv_next = data_reg[0];
                     end
                     addr_next  = 1'b0;
                     ctrl_next[tmt_pkg::CTL_FLAG] = 1'b1;
                     state_next = S_HOLD;
                  end else if (bit_reg == 4'h0) begin
                     sdal_next  = 1'b0; // release sda for the ack
                     state_next = S_ACK;
                  end else begin
                     bit_next   = bit_reg - 4'h1;
                     sdal_next  = !data_reg[3'(bit_reg - 4'h1)];
                  end
               end
            end
         end
         S_STOP: begin
            if (half) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == 2'h0) begin
                  scll_next = 1'b0;
               end else begin
                  sdal_next  = 1'b0;
                  own_next   = 1'b0;
                  send_next  = 1'b0;
                  recv_next  = 1'b0;
                  stat_next  = tmt_pkg::ST_MASK;
                  ctrl_next[tmt_pkg::CTL_STOP] = 1'b0;
                  state_next = S_IDLE;
               end
            end
         end
         default: state_next = S_IDLE;
      endcase
      // disabling the interface drops the bus at once
      if (!ctrl_reg[tmt_pkg::CTL_EN]) begin
         state_next = S_IDLE;
         scll_next  = 1'b0;
         sdal_next  = 1'b0;
         own_next   = 1'b0;
      end
      // read data one cycle after the strobe, reserved bit reads zero
      rdata_next = 8'h00;
      if (i_rd) begin
         case (i_addr)
            tmt_pkg::ADDR_CTRL:   rdata_next = ctrl_reg & 8'hfd;
            tmt_pkg::ADDR_STATUS: rdata_next = stat_reg;
            tmt_pkg::ADDR_DATA:   rdata_next = data_reg;
            default:              rdata_next = 8'h00;
         endcase
      end
   end

   // state registers
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= S_IDLE;
         ctrl_reg  <= tmt_pkg::CTRL_RESET;
         stat_reg  <= tmt_pkg::STATUS_IDLE;
         data_reg  <= tmt_pkg::DATA_RESET;
         rdata_reg <= 8'h00;
         cnt_reg   <= 16'h0000;
         ph_reg    <= 2'h0;
         bit_reg   <= 4'h0;
         addr_reg  <= 1'b0;
         own_reg   <= 1'b0;
         scll_reg  <= 1'b0;
         sdal_reg  <= 1'b0;
         send_reg  <= 1'b0;
         recv_reg  <= 1'b0;
         busy_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         ctrl_reg  <= ctrl_next;
         stat_reg  <= stat_next;
         data_reg  <= data_next;
         rdata_reg <= rdata_next;
         cnt_reg   <= cnt_next;
         ph_reg    <= ph_next;
         bit_reg   <= bit_next;
         addr_reg  <= addr_next;
         own_reg   <= own_next;
         scll_reg  <= scll_next;
         sdal_reg  <= sdal_next;
         send_reg  <= send_next;
         recv_reg  <= recv_next;
         busy_reg  <= busy_next;
      end
   end

   // open drain: only ever drive low
   assign o_scl       = 1'b0;
   assign o_sda       = 1'b0;
   assign o_scl_oe    = scll_reg;
   assign o_sda_oe    = sdal_reg;
   assign o_rdata     = rdata_reg;
   assign o_mode_send = send_reg;
   assign o_mode_recv = recv_reg;
endmodule : tmt_master_tx

// ==== design/tmt_pkg.sv ====
// package: register map, field layout and status codes of the two-wire master sender
package tmt_pkg;
   // register addresses on the plain register port
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_DATA   = 2'h2;
   // control register bit positions
   localparam int CTL_FLAG  = 7;
   localparam int CTL_ACKEN = 6;
   localparam int CTL_START = 5;
   localparam int CTL_STOP  = 4;
   localparam int CTL_WCOL  = 3;
   localparam int CTL_EN    = 2;
   localparam int CTL_IRQEN = 0;
   // reset values
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] STATUS_IDLE  = 8'hf8;
   localparam logic [7:0] DATA_RESET   = 8'hff;
   // status codes, prescaler bits zero
   localparam logic [7:0] ST_START     = 8'h08;
   localparam logic [7:0] ST_RSTART    = 8'h10;
   localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
   localparam logic [7:0] ST_ADDR_NACK = 8'h20;
   localparam logic [7:0] ST_DATA_ACK  = 8'h28;
   localparam logic [7:0] ST_DATA_NACK = 8'h30;
   localparam logic [7:0] ST_ARB_LOST  = 8'h38;
   localparam logic [7:0] ST_MASK      = 8'hf8;
   // timing: half period of the serial clock
   localparam int HALF_NS     = 5000;
   localparam int CLK_NS      = 8;
   localparam int HALF_CYC    = (HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int BIT_LAST    = 7;
   localparam int BITS_BYTE   = 8;
endpackage : tmt_pkg

// ==== tb/tmt_master_tx_chk.sv ====
// checker: port-level properties of the two-wire master sender
module tmt_master_tx_chk #(
   parameter int HALF_CYCLES = 4
) (
   // clock and reset
   input wire logic       i_mclk,
   input wire logic       i_nrst,
   // register port
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // bus drive and mode
   input wire logic       o_scl_oe,
   input wire logic       o_sda_oe,
   input wire logic       o_mode_send,
   input wire logic       o_mode_recv
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        prev_reg, prev_next;
   logic [15:0] run_reg, run_next;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // cycles since the clock drive last moved
   always_comb begin
      prev_next = o_scl_oe;
      run_next  = (o_scl_oe != prev_reg) ? 16'h0000 : run_reg + 16'h0001;
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         prev_reg <= 1'b0;
         run_reg  <= 16'h0000;
      end else begin
         prev_reg <= prev_next;
         run_reg  <= run_next;
      end
   end
   property p_rd_idle;
      !$past(i_rd) |-> o_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_rsv;
      $past(i_rd) && $past(i_addr) == tmt_pkg::ADDR_CTRL |-> !o_rdata[1];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_st_low;
      $past(i_rd) && $past(i_addr) == tmt_pkg::ADDR_STATUS |-> o_rdata[2:0] == 3'h0;
   endproperty
   a_st_low: assert property (p_st_low) else $error("prescaler bits set");
   property p_flag_clr;
      i_wr && i_addr == tmt_pkg::ADDR_CTRL && i_wdata[7] ##2 i_rd && i_addr == 2'h0
         |=> !o_rdata[7] && !o_rdata[3];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
   property p_hold;
      $past(i_rd) && $past(i_addr) == tmt_pkg::ADDR_CTRL && o_rdata[7] |-> ##[0:12] o_scl_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("clock not held low");
   property p_stop;
      $fell(o_sda_oe) && !o_scl_oe |=> !o_scl_oe [*8];
   endproperty
   a_stop: assert property (p_stop) else $error("clock driven after stop");
   property p_gap;
      o_scl_oe != prev_reg |-> run_reg >= 16'(HALF_CYCLES - 1);
   endproperty
   a_gap: assert property (p_gap) else $error("clock phase too short");
   property p_mode;
      !(o_mode_send && o_mode_recv);
   endproperty
   a_mode: assert property (p_mode) else $error("both modes set");
   c_data: cover property (i_wr && i_addr == tmt_pkg::ADDR_DATA);
   c_stop: cover property ($fell(o_sda_oe) && !o_scl_oe);
   c_recv: cover property (o_mode_recv);
endmodule : tmt_master_tx_chk

bind tmt_master_tx tmt_master_tx_chk #(.HALF_CYCLES(HALF_CYCLES)) chk_i (
   .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
   .o_mode_send(o_mode_send), .o_mode_recv(o_mode_recv));

// ==== tb/tmt_master_tx_tb_top.sv ====
// testbench: register-driven transfers against the slave model
module tmt_master_tx_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] AC = tmt_pkg::ADDR_CTRL;
   localparam logic [1:0] AS = tmt_pkg::ADDR_STATUS;
   localparam logic [1:0] AD = tmt_pkg::ADDR_DATA;
   logic       i_mclk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [1:0] i_addr = 2'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata, slv_last;
   logic       o_scl, o_sda, o_scl_oe, o_sda_oe, o_mode_send, o_mode_recv, slv_oe;
   wire        scl_w = !o_scl_oe;
   // sda lags scl a little: both drives move on one edge, the model must see scl first
   wire #2     sda_w = !(o_sda_oe || slv_oe);
   int         errors = 0, n_tests = 0;
   always #4 i_mclk = ~i_mclk;
   // ten cycles a half bit gives the 160 ns link clock
   tmt_master_tx #(.HALF_CYCLES(10)) tmt_master_tx_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_scl(scl_w), .i_sda(sda_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .o_sda(o_sda),
      .o_sda_oe(o_sda_oe), .o_mode_send(o_mode_send), .o_mode_recv(o_mode_recv));
   tmt_slave_model tmt_slave_model_i (.i_scl(scl_w), .i_sda(sda_w), .o_sda_oe(slv_oe),
      .o_last(slv_last));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd
   // control write, then poll for the flag, bounded
   task automatic ev(input logic [7:0] ctl, input logic [7:0] st);
      logic [7:0] d;
      int         k;
      wr(AC, ctl);
      rd(AC, d);
      chk(d & 8'h88, 8'h00);
      k = 0;
      do begin
         rd(AC, d);
         k++;
      end while (d[7] !== 1'b1 && k < 400);
      chk({7'h00, d[7]}, 8'h01);
      rd(AS, d);
      chk(d & tmt_pkg::ST_MASK, st);
   endtask : ev
   task automatic stop;
      logic [7:0] d;
      int         k;
      wr(AC, 8'h94);
      k = 0;
      do begin
         rd(AC, d);
         k++;
      end while (d[4] !== 1'b0 && k < 400);
      chk(d & 8'hb4, 8'h04);
      rd(AS, d);
      chk(d, tmt_pkg::STATUS_IDLE);
   endtask : stop
   task automatic t_reset_coll;
      logic [7:0] d;
      rd(AC, d);
      chk(d, tmt_pkg::CTRL_RESET);
      chk({6'h00, o_scl, o_sda}, 8'h00);
      rd(2'h3, d);
      chk(d, 8'h00);
      wr(AD, 8'h33);
      rd(AD, d);
      chk(d, tmt_pkg::DATA_RESET);
      rd(AC, d);
      chk(d, 8'h08);
   endtask : t_reset_coll
   // write, nacked byte, repeated start, read address, stop
   task automatic t_send;
      ev(8'ha4, tmt_pkg::ST_START);
      wr(AD, 8'ha0);
      ev(8'h84, tmt_pkg::ST_ADDR_ACK);
      chk({7'h00, o_mode_send}, 8'h01);
      wr(AD, 8'h5a);
      ev(8'h84, tmt_pkg::ST_DATA_ACK);
      chk(slv_last, 8'h5a);
      wr(AD, 8'hee);
      ev(8'h84, tmt_pkg::ST_DATA_NACK);
      ev(8'ha4, tmt_pkg::ST_RSTART);
      wr(AD, 8'ha1);
      ev(8'h84, tmt_pkg::ST_ADDR_ACK);
      chk({7'h00, o_mode_recv}, 8'h01);
      stop();
      ev(8'ha4, tmt_pkg::ST_START);
      wr(AD, 8'hb0);
      ev(8'h84, tmt_pkg::ST_ADDR_NACK);
      stop();
   endtask : t_send
   task automatic summarize;
      $display("errors %0d of %0d checks", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (8) @(posedge i_mclk);
      i_nrst <= 1'b1;
      t_reset_coll();
      t_send();
      summarize();
   end
   // watchdog well above the expected run of under two thousand cycles
   initial begin
      repeat (30000) @(posedge i_mclk);
      errors++;
      summarize();
   end
endmodule : tmt_master_tx_tb_top

// ==== tb/tmt_slave_model.sv ====
// behavioural slave receiver, acks its own address and all bytes but one
module tmt_slave_model #(
   parameter logic [6:0] DEV_ADDR  = 7'h50,
   parameter logic [7:0] NACK_BYTE = 8'hee
) (
   // resolved bus lines
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   // pull-down and last data byte
   output logic            o_sda_oe,
   output logic      [7:0] o_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       p_scl = 1'b1, p_sda = 1'b1, active = 1'b0, first = 1'b0, ok = 1'b0;
   logic [7:0] sh = 8'h00;
   int         cnt = 0;
   initial o_sda_oe = 1'b0;
   initial o_last = 8'h00;
   // edges of both lines; stale p_sda after own drive is harmless, clock is low
   always @(i_scl, i_sda) begin
      if (i_scl && p_scl && p_sda && !i_sda) begin
         // a repeated start begins a new address phase
         active = 1'b1;
         first = 1'b1;
         cnt = 0;
      end else if (i_scl && p_scl && !p_sda && i_sda) begin
         active = 1'b0;
      end else if (i_scl && !p_scl && active && cnt < 8) begin
         sh = {sh[6:0], i_sda};
         cnt++;
      end else if (!i_scl && p_scl && active && cnt == 8) begin
         ok = first ? (sh[7:1] == DEV_ADDR) : (sh != NACK_BYTE);
         o_sda_oe = ok;
         if (!first) o_last = sh;
         cnt = 9;
      end else if (!i_scl && p_scl && cnt == 9) begin
         o_sda_oe = 1'b0;
         active = ok;
         first = 1'b0;
         cnt = 0;
      end
      p_scl = i_scl;
      p_sda = i_sda;
   end
endmodule : tmt_slave_model
